// file: core/transceiver_mode_serial_config.sv
// Purpose: mode pins, serial control port and control-word latches
// Assumes: mclk 25 MHz, serial clock far slower (8+ samples a period)
// Notes:   all pins pass two flops; bus stalls while ce is low
//
// Summary of operation
// - ask: data 0 kills amplifier, 1 enables
// - fsk: data low closes pulling switch
// - power-up starts in stand-alone operation
// - two select pins choose the channel
// - receive divider defaults follow the channel
// - transmit dividers: same reference, own feedback
// - rx/tx pins pick standby, receive, transmit, idle
// - pulled-down mode pins mean standby
// - pins choose modulation and amplifier gain
// - first select-0 transition enters programmable operation
// - serial data shifted msb first, 24 bits
// - latch edge copies word by top bits
// - word is two address, 22 data bits
// - surplus leading bits fall off
// - other three latches stay untouched
// - words accepted in every mode
// - mode changes keep latched words
// - entry loads defaults from prior pins
`timescale 1ns/1ps
module transceiver_mode_serial_config
(
    input  wire logic                        mclk,
    input  wire logic                        rst_b,
    input  wire logic                        ce,
    input  wire logic                        freq_sel0_latch_enable_pin,
    input  wire logic                        freq_sel1_lock_detect_pin,
    input  wire logic                        rx_enable_serial_clock_pin,
    input  wire logic                        tx_enable_serial_data_pin,
    input  wire logic                        modulation_select_pin,
    input  wire logic                        low_noise_amp_gain_pin,
    input  wire logic                        tx_data_input,
    output logic                             pa_enable,
    output logic                             fsk_switch_closed,
    output logic                             programmable_operation,
    output transceiver_cfg_pkg::radio_cfg_s  radio_cfg,
    output transceiver_cfg_pkg::synth_div_s  synth_div,
    input  wire logic                        hsel,
    input  wire logic [31:0]                 haddr,
    input  wire logic [1:0]                  htrans,
    input  wire logic                        hwrite,
    input  wire logic [2:0]                  hsize,
    input  wire logic [31:0]                 hwdata,
    input  wire logic                        hready,
    output logic                             hreadyout,
    output logic                             hresp,
    output logic [31:0]                      hrdata
);
    import transceiver_cfg_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [2:0]            sel0;   // s1, s2, previous
        logic [1:0]            sel1;
        logic [2:0]            sclk;
        logic [1:0]            sdat;
        logic [1:0]            mods;
        logic [1:0]            gain;
        logic [1:0]            txd;
        logic [1:0]            start_cnt;
        logic                  prog;
        ctrl_word_t            shift;
        logic [3:0][23:0]      words;
        logic                  dp_valid;
        logic                  dp_write;
        logic [7:0]            dp_addr;
        logic [31:0]           rdata;
        radio_cfg_s            cfg;
        synth_div_s            div;
        logic                  pa;
        logic                  fsw;
    } state_s;

    state_s     r_reg;
    state_s     r_next;
    logic       settled;
    logic       sel0_edge;
    logic       sel0_rise;
    logic       sclk_rise;
    logic [1:0] chan;
    logic [1:0] chan_prev;
    logic       txd_eff;
    logic       restart;
    radio_cfg_s eff_cfg;
    synth_div_s eff_div;
    ctrl_word_t eff_word [4];

    // ----------------------------------------------------------------
    // pin events
    // ----------------------------------------------------------------
    // pins pass two flops first; the third select-0 and serial clock
    // stage only keeps the old level for edge finding
    // the previous stage is only trusted once the chain has filled,
    // otherwise reset values would fake a first transition
    assign settled   = (r_reg.start_cnt == START_SETTLE);
    assign sel0_edge = settled && (r_reg.sel0[1] != r_reg.sel0[0]);
    assign sel0_rise = r_reg.sel0[1] && !r_reg.sel0[0];
    assign sclk_rise = r_reg.sclk[1] && !r_reg.sclk[0];
    assign chan      = {r_reg.sel1[0], r_reg.sel0[1]};
    assign chan_prev = {r_reg.sel1[0], r_reg.sel0[0]};

    // only a write data phase may return to stand-alone; hwdata is
    // valid in the cycle after the address was taken
    assign restart = r_reg.dp_valid && r_reg.dp_write &&
                     (r_reg.dp_addr == CTRL_OFFSET) &&
                     hwdata[RESTART_BIT];

    // ----------------------------------------------------------------
    // effective configuration
    // ----------------------------------------------------------------
    // one view of the four words for both modes, so bus readback and
    // the synthesiser outputs can never disagree
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            if (r_reg.prog)
                eff_word[i] = r_reg.words[i];
            else
                eff_word[i] = default_word(chan, 2'(i));
        end
        eff_div.rx_ref = eff_word[0][9:0];
        eff_div.tx_ref = eff_word[1][9:0];
        eff_div.rx_fb  = eff_word[2][16:0];
        eff_div.tx_fb  = eff_word[3][16:0];
        if (r_reg.prog)
        begin
            eff_cfg.mode    = op_mode_e'(eff_word[0][OPMODE_LO +: 2]);
            eff_cfg.fsk     = eff_word[0][MODS_BIT];
            eff_cfg.lna_low = !eff_word[0][LNAG_BIT];
            txd_eff = r_reg.txd[0] ^ eff_word[0][DPOL_BIT];
        end
        else
        begin
            // undriven pins sit low in the pad, giving standby
            case ({r_reg.sclk[1], r_reg.sdat[0]})
                2'b10:   eff_cfg.mode = MODE_RECEIVE;
                2'b01:   eff_cfg.mode = MODE_TRANSMIT;
                2'b11:   eff_cfg.mode = MODE_IDLE;
                default: eff_cfg.mode = MODE_STANDBY;
            endcase
            eff_cfg.fsk     = r_reg.mods[0];
            eff_cfg.lna_low = r_reg.gain[0];
            txd_eff = r_reg.txd[0];
        end
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        r_next = r_reg;
        if (ce)
        begin
            r_next.sel0 = {freq_sel0_latch_enable_pin, r_reg.sel0[2:1]};
            r_next.sel1 = {freq_sel1_lock_detect_pin, r_reg.sel1[1]};
            r_next.sclk = {rx_enable_serial_clock_pin, r_reg.sclk[2:1]};
            r_next.sdat = {tx_enable_serial_data_pin, r_reg.sdat[1]};
            r_next.mods = {modulation_select_pin, r_reg.mods[1]};
            r_next.gain = {low_noise_amp_gain_pin, r_reg.gain[1]};
            r_next.txd  = {tx_data_input, r_reg.txd[1]};
            if (!settled)
                r_next.start_cnt = 2'(r_reg.start_cnt + 2'h1);

            // software return to stand-alone; a pin transition in the
            // same cycle does not re-enter, so the return wins
            if (restart)
                r_next.prog = 1'b0;

            if (!r_reg.prog && sel0_edge)
            begin
                r_next.prog = 1'b1;
                for (int i = 0; i < 4; i++)
                    r_next.words[i] = default_word(chan_prev, 2'(i));
            end

            // accepted whatever the operating mode
            if (r_reg.prog)
            begin
                if (sclk_rise)
                    r_next.shift = {r_reg.shift[22:0], r_reg.sdat[0]};
                // a latch edge in the same cycle as a clock edge would
                // store the word without that bit; the host avoids it
                if (sel0_rise)
                    r_next.words[r_reg.shift[WSEL_HI:WSEL_LO]] =
                        r_reg.shift;
            end

            // mode changes never touch the latched words
            r_next.cfg = eff_cfg;
            r_next.div = eff_div;
            r_next.pa  = (eff_cfg.mode == MODE_TRANSMIT) &&
                         (eff_cfg.fsk || txd_eff);
            r_next.fsw = eff_cfg.fsk && !txd_eff;

            r_next.dp_valid = hsel && hready && htrans[1];
            r_next.dp_write = hwrite;
            r_next.dp_addr  = haddr[7:0];
            if (hsel && hready && htrans[1] && !hwrite)
            begin
                r_next.rdata = 32'h0000_0000;
                case (haddr[7:0])
                    STATUS_OFFSET:
                        r_next.rdata[7:0] = {r_reg.pa, chan,
                            r_reg.cfg.lna_low, r_reg.cfg.fsk,
                            r_reg.cfg.mode, r_reg.prog};
                    WORD_A_OFFSET, WORD_B_OFFSET,
                    WORD_C_OFFSET, WORD_D_OFFSET:
                        r_next.rdata[23:0] =
                            eff_word[2'((haddr[7:0] - WORD_A_OFFSET) >> 2)];
                    default:
                        r_next.rdata = 32'h0000_0000;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            r_reg <= '0;
        else
            r_reg <= r_next;
    end

    assign pa_enable              = r_reg.pa;
    assign fsk_switch_closed      = r_reg.fsw;
    assign programmable_operation = r_reg.prog;
    assign radio_cfg              = r_reg.cfg;
    assign synth_div              = r_reg.div;
    // frozen state cannot take a transfer, so the bus is held off
    assign hreadyout              = ce;
    assign hresp                  = 1'b0;
    assign hrdata                 = r_reg.rdata;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    ask_pa_gate_a: assert property (
        ce && !eff_cfg.fsk && eff_cfg.mode == MODE_TRANSMIT
        |=> pa_enable == $past(txd_eff))
        else $error("amplifier does not follow ask data");

    fsk_switch_a: assert property (
        ce && eff_cfg.fsk |=> fsk_switch_closed == !$past(txd_eff))
        else $error("pulling switch wrong for data level");

    powerup_alone_a: assert property (
        !settled |-> !r_reg.prog)
        else $error("programmable before pins settled");

    alone_div_a: assert property (
        ce && !r_reg.prog
        |=> synth_div.rx_ref == REF_DIV_DEFAULT[$past(chan)] &&
            synth_div.tx_ref == synth_div.rx_ref &&
            synth_div.tx_fb == TX_FB_DEFAULT[$past(chan)])
        else $error("stand-alone dividers wrong");

    mode_pins_a: assert property (
        ce && !r_reg.prog && r_reg.sclk[1] && !r_reg.sdat[0]
        |=> radio_cfg.mode == MODE_RECEIVE)
        else $error("receive pins not decoded");

    gain_mod_a: assert property (
        ce && !r_reg.prog
        |=> radio_cfg.fsk == $past(r_reg.mods[0]) &&
            radio_cfg.lna_low == $past(r_reg.gain[0]))
        else $error("modulation or gain pin ignored");

    entry_load_a: assert property (
        ce && !r_reg.prog && sel0_edge
        |=> r_reg.prog ##0
            r_reg.words[2][16:0] == RX_FB_DEFAULT[$past(chan_prev)])
        else $error("entry or entry defaults wrong");

    shift_in_a: assert property (
        ce && r_reg.prog && sclk_rise
        |=> r_reg.shift == {$past(r_reg.shift[22:0]),
                            $past(r_reg.sdat[0])})
        else $error("serial bit not shifted in");

    latch_one_a: assert property (
        ce && r_reg.prog && sel0_rise && r_reg.shift[23:22] == 2'h1
        |=> r_reg.words[1] == $past(r_reg.shift) &&
            r_reg.words[0] == $past(r_reg.words[0]) &&
            r_reg.words[3] == $past(r_reg.words[3]))
        else $error("latch selection wrong");

    words_hold_a: assert property (
        r_reg.prog && !(ce && sel0_rise) |=> $stable(r_reg.words))
        else $error("latched words changed without latch edge");

    pa_off_a: assert property (
        ce && eff_cfg.mode != MODE_TRANSMIT |=> !pa_enable)
        else $error("amplifier on outside transmit");

    fsk_pa_on_a: assert property (
        ce && eff_cfg.fsk && eff_cfg.mode == MODE_TRANSMIT
        |=> pa_enable)
        else $error("amplifier off in fsk transmit");

    // the receive feedback entry of the stand-alone table, per channel
    alone_rxfb_a: assert property (
        ce && !r_reg.prog
        |=> synth_div.rx_fb == RX_FB_DEFAULT[$past(chan)])
        else $error("stand-alone receive feedback wrong");

    entry_ref_a: assert property (
        ce && !r_reg.prog && sel0_edge
        |=> r_reg.words[0][9:0] == REF_DIV_DEFAULT[$past(chan_prev)] &&
            r_reg.words[3][16:0] == TX_FB_DEFAULT[$past(chan_prev)])
        else $error("entry reference or transmit default wrong");

    // any address code, not only the one a scenario happens to use
    latch_addr_a: assert property (
        ce && r_reg.prog && sel0_rise
        |=> r_reg.words[$past(r_reg.shift[WSEL_HI:WSEL_LO])] ==
            $past(r_reg.shift))
        else $error("word stored under wrong address");

    restart_clear_a: assert property (
        ce && restart && r_reg.prog |=> !r_reg.prog)
        else $error("software return to stand-alone lost");

    cover property (ce && !r_reg.prog && sel0_edge);
    cover property (r_reg.prog && sel0_rise &&
                    r_reg.shift[WSEL_HI:WSEL_LO] == 2'h3);
    cover property (ce && r_reg.prog && sel0_rise);
    cover property (pa_enable ##1 !pa_enable);
    cover property (r_reg.prog ##1 !r_reg.prog);

endmodule : transceiver_mode_serial_config

// file: inc/transceiver_cfg_pkg.sv
// Purpose: shared constants and types of the transceiver control block
// Assumes: 24-bit control words, four latches
// Notes:   register offsets are byte addresses on AHB-Lite
package transceiver_cfg_pkg;

    // ----------------------------------------------------------------
    // bus map
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_OFFSET   = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] WORD_A_OFFSET = 8'h08;
    localparam logic [7:0] WORD_B_OFFSET = 8'h0c;
    localparam logic [7:0] WORD_C_OFFSET = 8'h10;
    localparam logic [7:0] WORD_D_OFFSET = 8'h14;
    localparam int         RESTART_BIT   = 0;

    // ----------------------------------------------------------------
    // control word fields
    // ----------------------------------------------------------------
    localparam int WSEL_HI   = 23;
    localparam int WSEL_LO   = 22;
    localparam int OPMODE_LO = 10;
    localparam int LNAG_BIT  = 12;
    localparam int MODS_BIT  = 19;
    localparam int DPOL_BIT  = 20;
    localparam int BAND_BIT  = 17;
    localparam int VCOC_LO   = 18;
    localparam logic [11:0] A_UPPER_RESET = 12'h07c;
    localparam logic [11:0] B_UPPER_RESET = 12'h73a;
    localparam logic [4:0]  D_UPPER_RESET = 5'h04;
    localparam logic [1:0]  START_SETTLE  = 2'h3;

    // channel tables indexed by {sel1, sel0}
    localparam logic [3:0][9:0]  REF_DIV_DEFAULT =
        {10'h012, 10'h020, 10'h020, 10'h010};
    localparam logic [3:0][16:0] RX_FB_DEFAULT =
        {17'h002fe, 17'h00fcf, 17'h00766, 17'h0077f};
    localparam logic [3:0][16:0] TX_FB_DEFAULT =
        {17'h00319, 17'h00fff, 17'h00796, 17'h00797};
    localparam logic [3:0]       BAND_DEFAULT = 4'h5;
    localparam logic [3:0][1:0]  VCOC_DEFAULT = {2'h0, 2'h3, 2'h1, 2'h3};

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_STANDBY, MODE_RECEIVE, MODE_TRANSMIT, MODE_IDLE
    } op_mode_e;

    typedef logic [23:0] ctrl_word_t;

    typedef struct packed {
        op_mode_e mode;
        logic     fsk;
        logic     lna_low;
    } radio_cfg_s;

    typedef struct packed {
        logic [9:0]  rx_ref;
        logic [16:0] rx_fb;
        logic [9:0]  tx_ref;
        logic [16:0] tx_fb;
    } synth_div_s;

    function automatic ctrl_word_t default_word(
        input logic [1:0] chan,
        input logic [1:0] idx
    );
        ctrl_word_t w;
        w = '0;
        case (idx)
            2'h0: w = {2'h0, A_UPPER_RESET, REF_DIV_DEFAULT[chan]};
            2'h1: w = {2'h1, B_UPPER_RESET, REF_DIV_DEFAULT[chan]};
            2'h2: w = {2'h2, 2'h0, VCOC_DEFAULT[chan],
                       BAND_DEFAULT[chan], RX_FB_DEFAULT[chan]};
            default: w = {2'h3, D_UPPER_RESET, TX_FB_DEFAULT[chan]};
        endcase
        return w;
    endfunction : default_word

endpackage : transceiver_cfg_pkg

// file: test/host_pins_model.sv
// Purpose: host side of the mode pins and the three-wire serial port
// Assumes: all pin changes follow a rising mclk; serial period 8 mclk
// Notes:   released serial data shows the inverse of the last bit
`timescale 1ns/1ps
module host_pins_model
(
    input  wire logic mclk,
    output logic      sel0,
    output logic      sel1,
    output logic      sclk,
    output logic      sdat,
    output logic      mod_sel,
    output logic      lna_sel,
    output logic      txd
);
    initial
    begin
        {sel1, sel0, sclk, sdat, mod_sel, lna_sel, txd} = 7'h00;
    end

    // ------------------------------------------------------------
    // stand-alone pins: {sel1, sel0, rx, tx, mod, lna, txd}
    // ------------------------------------------------------------
    task automatic set_pins(input logic [6:0] p);
        @(posedge mclk);
        {sel1, sel0, sclk, sdat, mod_sel, lna_sel, txd} <= p;
    endtask : set_pins

    // ------------------------------------------------------------
    // serial word: 28 bits so four surplus bits lead every frame
    // ------------------------------------------------------------
    task automatic send_word(input logic [27:0] w);
        @(posedge mclk);
        for (int i = 27; i >= 0; i--)
        begin
            sdat <= w[i];
            repeat (4) @(posedge mclk);
            sclk <= 1'b1;
            repeat (4) @(posedge mclk);
            sclk <= 1'b0;
        end
        // released data line must not look like a held bit
        sdat <= ~w[0];
        repeat (4) @(posedge mclk);
        sel0 <= 1'b1;
        repeat (4) @(posedge mclk);
        sel0 <= 1'b0;
    endtask : send_word
endmodule : host_pins_model

// file: test/tb_top.sv
// Purpose: self-checking bench of the mode pins and serial port
// Assumes: zero-wait AHB-Lite slave, ce held high
// Notes:   each channel is entered by reset so select-0 stays steady
`timescale 1ns/1ps
module tb_top;
    import transceiver_cfg_pkg::*;
    localparam int          SETTLE = 6;
    localparam logic [9:0]  REF_T [4] =
        '{10'h010, 10'h020, 10'h020, 10'h012};
    localparam logic [16:0] RXF_T [4] =
        '{17'h0077f, 17'h00766, 17'h00fcf, 17'h002fe};
    localparam logic [16:0] TXF_T [4] =
        '{17'h00797, 17'h00796, 17'h00fff, 17'h00319};
    localparam op_mode_e    MODE_T [4] =
        '{MODE_STANDBY, MODE_TRANSMIT, MODE_RECEIVE, MODE_IDLE};
    localparam logic [27:0] WORDS [5] = '{
        {4'hf, 2'h3, 5'h04, 17'h003e8}, {4'h0, 2'h2, 5'h00, 17'h001f4},
        {4'h5, 2'h0, 12'h001, 10'h018}, {4'ha, 2'h1, 12'h000, 10'h014},
        {4'h3, 2'h0, 12'h002, 10'h018}};
    localparam synth_div_s  DIVS [5] = '{
        {10'h012, 17'h002fe, 10'h012, 17'h003e8},
        {10'h012, 17'h001f4, 10'h012, 17'h003e8},
        {10'h018, 17'h001f4, 10'h012, 17'h003e8},
        {10'h018, 17'h001f4, 10'h014, 17'h003e8},
        {10'h018, 17'h001f4, 10'h014, 17'h003e8}};
    localparam op_mode_e    MODES [5] = '{MODE_STANDBY, MODE_STANDBY,
        MODE_RECEIVE, MODE_RECEIVE, MODE_TRANSMIT};

    logic        mclk, rst_b, hsel, hwrite, hreadyout, hresp;
    logic        pa_enable, fsk_sw, prog;
    logic        sel0, sel1, sclk, sdat, mod_sel, lna_sel, txd;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, rd;
    radio_cfg_s  cfg;
    synth_div_s  div;
    int          fail_count;
    int          check_count;

    host_pins_model host_u (.mclk(mclk), .sel0(sel0), .sel1(sel1),
        .sclk(sclk), .sdat(sdat), .mod_sel(mod_sel), .lna_sel(lna_sel),
        .txd(txd));

    transceiver_mode_serial_config dut_u (.mclk(mclk), .rst_b(rst_b),
        .ce(1'b1), .freq_sel0_latch_enable_pin(sel0),
        .freq_sel1_lock_detect_pin(sel1), .rx_enable_serial_clock_pin(sclk),
        .tx_enable_serial_data_pin(sdat), .modulation_select_pin(mod_sel),
        .low_noise_amp_gain_pin(lna_sel), .tx_data_input(txd),
        .pa_enable(pa_enable), .fsk_switch_closed(fsk_sw),
        .programmable_operation(prog), .radio_cfg(cfg), .synth_div(div),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // ------------------------------------------------------------
    // reporting
    // ------------------------------------------------------------
    task automatic give_verdict();
        if (fail_count == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict

    task automatic check(input string what, input logic [63:0] seen,
                         input logic [63:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // ------------------------------------------------------------
    // bus and reset
    // ------------------------------------------------------------
    task automatic wait_ready();
        int n;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1)
        begin
            fail_count++;
            give_verdict();
        end
    endtask : wait_ready

    task automatic ahb(input logic wr, input logic [31:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge mclk);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        q = hrdata;
        check("hresp", hresp, 1'b0);
    endtask : ahb

    // pins change only while reset is held, so no entry is triggered
    task automatic restart(input logic [6:0] p);
        @(posedge mclk);
        rst_b <= 1'b0;
        host_u.set_pins(p);
        repeat (5) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (SETTLE) @(posedge mclk);
    endtask : restart

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        rst_b = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'h0;
        haddr = '0;
        hwdata = '0;
        fail_count = 0;
        check_count = 0;
        for (int c = 0; c < 4; c++)
        begin
            restart({c[1], c[0], 5'h00});
            check("synth_div", div,
                  {REF_T[c], RXF_T[c], REF_T[c], TXF_T[c]});
            check("prog", prog, 1'b0);
        end
        for (int m = 0; m < 4; m++)
        begin
            host_u.set_pins({2'h3, m[1], m[0], m[0], m[1], 1'b0});
            repeat (SETTLE) @(posedge mclk);
            check("mode", cfg.mode, MODE_T[m]);
            check("fsk", cfg.fsk, m[0]);
            check("lna_low", cfg.lna_low, m[1]);
        end
        for (int k = 0; k < 4; k++)
        begin
            host_u.set_pins({2'h3, 2'h1, k[1], 1'b0, k[0]});
            repeat (SETTLE) @(posedge mclk);
            check("pa", pa_enable, k[0] | k[1]);
            if (k[1])
                check("switch", fsk_sw, !k[0]);
        end
        host_u.set_pins(7'h60);
        host_u.set_pins(7'h40);
        repeat (SETTLE) @(posedge mclk);
        check("prog", prog, 1'b1);
        check("synth_div", div,
              {REF_T[3], RXF_T[3], REF_T[3], TXF_T[3]});
        ahb(1'b0, {24'h0, STATUS_OFFSET}, 32'h0, rd);
        check("status", rd[0], 1'b1);
        for (int w = 0; w < 5; w++)
        begin
            host_u.send_word(WORDS[w]);
            repeat (SETTLE) @(posedge mclk);
            check("synth_div", div, DIVS[w]);
            check("mode", cfg.mode, MODES[w]);
        end
        ahb(1'b0, {24'h0, WORD_D_OFFSET}, 32'h0, rd);
        check("word_d", rd[23:0], WORDS[0][23:0]);
        ahb(1'b1, {24'h0, CTRL_OFFSET}, 32'h1, rd);
        repeat (SETTLE) @(posedge mclk);
        check("prog", prog, 1'b0);
        check("synth_div", div,
              {REF_T[2], RXF_T[2], REF_T[2], TXF_T[2]});
        ahb(1'b0, 32'h40, 32'h0, rd);
        check("unmapped", rd, 32'h0);
        give_verdict();
    end
endmodule : tb_top
